// [bcm_ballast_monitor.sv]
// ballast chopper control and thermal monitor with wishbone registers
`timescale 1ns/1ns
`default_nettype none
// Contract
// - One dedicated output pin drives the external ballast driver, switch and resistor.
// - Switching happens only while the enable bit of the control word is set, else inactive.
// - The pin is active high, and the invert bit of the control word flips its polarity.
// - A threshold and a hysteresis in millivolts are held and steer the on/off decision.
// - A link voltage above the overvoltage limit raises an error and shuts the output stage.
// - Resistor energy is summed continuously while the convection cooling is subtracted.
// - Energy above the limit inhibits switching on and logs the overload warning code.
// - Once the resistor has cooled enough the inhibit lifts by itself.
// - Energy of one surge shorter than a second is checked against the short-term limit.
// - Energy inside the long-term window is checked against the long-term limit.
// - Invalid or unrealistic resistor parameters log the parameter fault code.
module bcm_ballast_monitor
  import bcm_pkg::*;
#(
  parameter int unsigned TICK_CYC = bcm_pkg::TICK_CYCLES
)(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // converter side
  input  wire logic [15:0] dclink_mv_i,
  output logic             ballast_o,
  output logic             stage_off_o
);
  import bcm_pkg::*;

  // register state
  logic [1:0]  ctrl_q;
  logic [15:0] thresh_q, hyst_q, ov_limit_q;
  logic [31:0] res_q, cool_q, st_limit_q, lt_limit_q, lt_window_q;
  logic        ov_err_q, ovl_warn_q;
  logic [15:0] err_code_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // behaviour state
  logic        hyst_on_q, inhibit_q, pfault_q, ballast_q, stage_off_q;
  logic [47:0] therm_q, surge_q, window_q;
  logic [31:0] tick_cnt_q, surge_age_q, win_cnt_q;

  // bus decode
  wire         bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
  wire         bus_wr   = bus_req && wb_we_i;
  wire         adr_hi0  = (wb_adr_i[31:8] == 24'h00_0000);
  wire [7:0]   adr      = wb_adr_i[7:0];
  wire [31:0]  wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire         wr_ctrl  = bus_wr && adr_hi0 && (adr == REG_CTRL);
  wire         wr_thr   = bus_wr && adr_hi0 && (adr == REG_THRESH);
  wire         wr_hys   = bus_wr && adr_hi0 && (adr == REG_HYST);
  wire         wr_ovl   = bus_wr && adr_hi0 && (adr == REG_OV_LIMIT);
  wire         wr_res   = bus_wr && adr_hi0 && (adr == REG_RES);
  wire         wr_cool  = bus_wr && adr_hi0 && (adr == REG_COOL);
  wire         wr_st    = bus_wr && adr_hi0 && (adr == REG_ST_LIMIT);
  wire         wr_lt    = bus_wr && adr_hi0 && (adr == REG_LT_LIMIT);
  wire         wr_win   = bus_wr && adr_hi0 && (adr == REG_LT_WINDOW);
  wire         wr_stat  = bus_wr && adr_hi0 && (adr == REG_STATUS);
  wire [31:0]  wdat     = wb_dat_i & wmask;
  wire         clr_ov   = wr_stat && wdat[ST_OV_ERR];
  wire         clr_warn = wr_stat && wdat[ST_OVL_WARN];

  // merge a write into a 32-bit field honouring byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  wire [31:0] m_thr  = merge({16'h0000, thresh_q}, wb_dat_i, wmask);
  wire [31:0] m_hys  = merge({16'h0000, hyst_q}, wb_dat_i, wmask);
  wire [31:0] m_ovl  = merge({16'h0000, ov_limit_q}, wb_dat_i, wmask);
  wire [31:0] m_ctrl = merge({30'h0000_0000, ctrl_q}, wb_dat_i, wmask);

  // switching decision
  wire         ctrl_en   = ctrl_q[CTRL_EN];
  wire         ctrl_inv  = ctrl_q[CTRL_INV];
  wire [16:0]  off_lvl   = (hyst_q > thresh_q) ? 17'h0_0000
                           : ({1'b0, thresh_q} - {1'b0, hyst_q});
  wire         above_thr = dclink_mv_i > thresh_q;
  wire         below_off = {1'b0, dclink_mv_i} < off_lvl;
  wire         hyst_on_d = pfault_q ? 1'b0 : (above_thr ? 1'b1 : (below_off ? 1'b0 : hyst_on_q));
  wire         active    = ctrl_en && !pfault_q && !inhibit_q && hyst_on_q;
  wire         over_volt = dclink_mv_i > ov_limit_q;

  // parameter validity: zero values or a short-term limit above the long-term one
  wire         pfault_d  = (res_q == 32'h0) || (cool_q == 32'h0) || (st_limit_q == 32'h0)
                           || (lt_limit_q == 32'h0) || (lt_window_q == 32'h0)
                           || (st_limit_q > lt_limit_q);

  // millisecond base and power estimate
  wire         tick      = (tick_cnt_q == (TICK_CYC - 1));
  wire         p_done;
  wire [31:0]  p_mw;
  bcm_power_div u_div (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .start_i (tick && !pfault_q),
    .num_i   ({16'h0000, dclink_mv_i} * {16'h0000, dclink_mv_i}),
    .den_i   (res_q),
    .busy_o  (),
    .done_o  (p_done),
    .quot_o  (p_mw)
  );

  // per-millisecond energy in microwatt-seconds
  wire [47:0]  e_in      = active ? {16'h0000, p_mw} : 48'h0;
  wire [47:0]  e_cool    = {16'h0000, cool_q};
  wire [47:0]  therm_sum = therm_q + e_in;
  wire [47:0]  therm_d   = (therm_sum > e_cool) ? (therm_sum - e_cool) : 48'h0;
  wire [47:0]  st_lim_u  = 48'(st_limit_q * MWS_TO_UWS);
  wire [47:0]  lt_lim_u  = 48'(lt_limit_q * MWS_TO_UWS);
  wire         win_end   = (win_cnt_q >= lt_window_q - 32'h1);
  wire         surge_ovl = (surge_q > st_lim_u) && (surge_age_q < SURGE_TICKS);
  wire         trip      = surge_ovl || (window_q > lt_lim_u) || (therm_q > lt_lim_u);
  wire         release_ok = (therm_q <= (lt_lim_u >> 1)) && !surge_ovl && (window_q <= lt_lim_u);

  // bus slave and register file
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q       <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      ctrl_q      <= CTRL_RESET;
      thresh_q    <= MV_RESET;
      hyst_q      <= MV_RESET;
      ov_limit_q  <= MV_RESET;
      res_q       <= PARAM_RESET;
      cool_q      <= PARAM_RESET;
      st_limit_q  <= PARAM_RESET;
      lt_limit_q  <= PARAM_RESET;
      lt_window_q <= PARAM_RESET;
    end else begin
      ack_q <= bus_req;
      if (wr_ctrl) ctrl_q <= m_ctrl[1:0];
      if (wr_thr) thresh_q <= m_thr[15:0];
      if (wr_hys) hyst_q <= m_hys[15:0];
      if (wr_ovl) ov_limit_q <= m_ovl[15:0];
      if (wr_res) res_q <= merge(res_q, wb_dat_i, wmask);
      if (wr_cool) cool_q <= merge(cool_q, wb_dat_i, wmask);
      if (wr_st) st_limit_q <= merge(st_limit_q, wb_dat_i, wmask);
      if (wr_lt) lt_limit_q <= merge(lt_limit_q, wb_dat_i, wmask);
      if (wr_win) lt_window_q <= merge(lt_window_q, wb_dat_i, wmask);
      if (bus_req && !wb_we_i) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    if (adr_hi0) begin
      unique case (adr)
        REG_CTRL:      rdata_d = {30'h0, ctrl_q};
        REG_THRESH:    rdata_d = {16'h0, thresh_q};
        REG_HYST:      rdata_d = {16'h0, hyst_q};
        REG_OV_LIMIT:  rdata_d = {16'h0, ov_limit_q};
        REG_RES:       rdata_d = res_q;
        REG_COOL:      rdata_d = cool_q;
        REG_ST_LIMIT:  rdata_d = st_limit_q;
        REG_LT_LIMIT:  rdata_d = lt_limit_q;
        REG_LT_WINDOW: rdata_d = lt_window_q;
        REG_STATUS:    rdata_d = {27'h0, ovl_warn_q, ov_err_q, pfault_q, inhibit_q, active};
        REG_ERR_CODE:  rdata_d = {16'h0, err_code_q};
        REG_ENERGY:    rdata_d = therm_q[41:10];
        default:       rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // switching, protection and flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hyst_on_q   <= 1'b0;
      pfault_q    <= 1'b0;
      inhibit_q   <= 1'b0;
      ballast_q   <= 1'b0;
      stage_off_q <= 1'b0;
      ov_err_q    <= 1'b0;
      ovl_warn_q  <= 1'b0;
      err_code_q  <= CODE_NONE;
    end else begin
      hyst_on_q   <= hyst_on_d;
      pfault_q    <= pfault_d;
      ballast_q   <= active ^ ctrl_inv;
      ov_err_q    <= over_volt || (ov_err_q && !clr_ov);
      stage_off_q <= over_volt || (ov_err_q && !clr_ov);
      // set beats clear on both sticky flags
      ovl_warn_q  <= (trip && !inhibit_q && !pfault_q) || (ovl_warn_q && !clr_warn);
      if (pfault_q) begin
        inhibit_q <= 1'b0;
      end else if (trip) begin
        inhibit_q <= 1'b1;
      end else if (inhibit_q && release_ok) begin
        inhibit_q <= 1'b0;
      end
      if (pfault_d && !pfault_q) begin
        err_code_q <= CODE_PARAM;
      end else if (!pfault_q && trip && !inhibit_q) begin
        err_code_q <= CODE_OVERLOAD;
      end
    end
  end

  // energy accounts, updated once per millisecond
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q  <= 32'h0000_0000;
      therm_q     <= 48'h0;
      surge_q     <= 48'h0;
      window_q    <= 48'h0;
      surge_age_q <= 32'h0000_0000;
      win_cnt_q   <= 32'h0000_0000;
    end else begin
      tick_cnt_q <= tick ? 32'h0000_0000 : tick_cnt_q + 32'h1;
      if (pfault_q) begin
        therm_q     <= 48'h0;
        surge_q     <= 48'h0;
        window_q    <= 48'h0;
        surge_age_q <= 32'h0000_0000;
        win_cnt_q   <= 32'h0000_0000;
      end else if (p_done) begin
        therm_q <= therm_d;
        // a surge ends whenever the switch opens
        surge_q     <= active ? surge_q + e_in : 48'h0;
        surge_age_q <= active ? surge_age_q + 32'h1 : 32'h0000_0000;
        window_q    <= win_end ? e_in : window_q + e_in;
        win_cnt_q   <= win_end ? 32'h0000_0000 : win_cnt_q + 32'h1;
      end
    end
  end

  assign wb_ack_o    = ack_q;
  assign wb_dat_o    = rdata_q;
  assign ballast_o   = ballast_q;
  assign stage_off_o = stage_off_q;

  // checks
  property p_disabled_idle;
    @(posedge clk_i) disable iff (rst_i)
    !ctrl_en |=> (ballast_q == $past(ctrl_inv));
  endproperty
  a_disabled_idle: assert property (p_disabled_idle) else $error("ballast active while disabled");

  property p_polarity;
    @(posedge clk_i) disable iff (rst_i)
    active |=> (ballast_q == !$past(ctrl_inv));
  endproperty
  a_polarity: assert property (p_polarity) else $error("ballast pin has wrong polarity");

  property p_turn_on;
    @(posedge clk_i) disable iff (rst_i)
    (!pfault_q && dclink_mv_i > thresh_q) |=> hyst_on_q;
  endproperty
  a_turn_on: assert property (p_turn_on) else $error("ballast not armed above threshold");

  property p_hold_band;
    @(posedge clk_i) disable iff (rst_i)
    (hyst_on_q && !pfault_q && {1'b0, dclink_mv_i} >= off_lvl) |=> hyst_on_q;
  endproperty
  a_hold_band: assert property (p_hold_band) else $error("ballast dropped inside hysteresis");

  property p_overvolt;
    @(posedge clk_i) disable iff (rst_i)
    over_volt |=> (ov_err_q && stage_off_o) ##1 ((ov_err_q && stage_off_o) || $past(clr_ov));
  endproperty
  a_overvolt: assert property (p_overvolt) else $error("overvoltage did not stop stage");

  property p_cooling;
    @(posedge clk_i) disable iff (rst_i)
    (p_done && !pfault_q && !active && therm_q != 48'h0) |=> (therm_q < $past(therm_q));
  endproperty
  a_cooling: assert property (p_cooling) else $error("energy account did not cool");

  property p_overload_code;
    @(posedge clk_i) disable iff (rst_i)
    ($rose(inhibit_q) && !$past(pfault_d)) |-> (err_code_q == CODE_OVERLOAD && ovl_warn_q);
  endproperty
  a_overload_code: assert property (p_overload_code) else $error("overload code missing");

  property p_trip_blocks;
    @(posedge clk_i) disable iff (rst_i)
    (trip && !pfault_q) |=> inhibit_q ##1 (ballast_q == $past(ctrl_inv));
  endproperty
  a_trip_blocks: assert property (p_trip_blocks) else $error("overload did not inhibit");

  property p_auto_release;
    @(posedge clk_i) disable iff (rst_i)
    (inhibit_q && !trip && release_ok && !pfault_q) |=> !inhibit_q;
  endproperty
  a_auto_release: assert property (p_auto_release) else $error("inhibit not lifted");

  property p_param_fault;
    @(posedge clk_i) disable iff (rst_i)
    $rose(pfault_q) |-> (err_code_q == CODE_PARAM) ##1 (therm_q == 48'h0 && !active);
  endproperty
  a_param_fault: assert property (p_param_fault) else $error("parameter fault not handled");

  property p_window_limit;
    @(posedge clk_i) disable iff (rst_i)
    (!pfault_q && window_q > lt_lim_u) |=> inhibit_q;
  endproperty
  a_window_limit: assert property (p_window_limit) else $error("window limit ignored");
endmodule : bcm_ballast_monitor
`default_nettype wire

// [bcm_pkg.sv]
// constants shared by the ballast chopper monitor
package bcm_pkg;
  // clock and time base
  localparam int unsigned CLK_MHZ        = 100;
  localparam int unsigned TICK_TIME_US   = 1000;
  localparam int unsigned TICK_CYCLES    = TICK_TIME_US * CLK_MHZ;
  localparam int unsigned SURGE_TIME_MS  = 1000;
  localparam int unsigned SURGE_TICKS    = SURGE_TIME_MS * 1000 / TICK_TIME_US;
  localparam logic [47:0] MWS_TO_UWS     = 48'h0000_0000_03E8;

  // register byte offsets
  localparam logic [7:0] REG_CTRL        = 8'h00;
  localparam logic [7:0] REG_THRESH      = 8'h04;
  localparam logic [7:0] REG_HYST        = 8'h08;
  localparam logic [7:0] REG_OV_LIMIT    = 8'h0C;
  localparam logic [7:0] REG_RES         = 8'h10;
  localparam logic [7:0] REG_COOL        = 8'h14;
  localparam logic [7:0] REG_ST_LIMIT    = 8'h18;
  localparam logic [7:0] REG_LT_LIMIT    = 8'h1C;
  localparam logic [7:0] REG_LT_WINDOW   = 8'h20;
  localparam logic [7:0] REG_STATUS      = 8'h24;
  localparam logic [7:0] REG_ERR_CODE    = 8'h28;
  localparam logic [7:0] REG_ENERGY      = 8'h2C;

  // control field positions
  localparam int unsigned CTRL_EN        = 0;
  localparam int unsigned CTRL_INV       = 1;

  // status field positions
  localparam int unsigned ST_ACTIVE      = 0;
  localparam int unsigned ST_INHIBIT     = 1;
  localparam int unsigned ST_PFAULT      = 2;
  localparam int unsigned ST_OV_ERR      = 3;
  localparam int unsigned ST_OVL_WARN    = 4;

  // reset values
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam logic [15:0] MV_RESET       = 16'h0000;
  localparam logic [31:0] PARAM_RESET    = 32'h0000_0000;

  // event codes
  localparam logic [15:0] CODE_NONE      = 16'h0000;
  localparam logic [15:0] CODE_OVERLOAD  = 16'h7113;
  localparam logic [15:0] CODE_PARAM     = 16'h7110;

  // divider
  localparam logic [5:0]  DIV_STEPS      = 6'h20;
endpackage : bcm_pkg

// [bcm_power_div.sv]
// serial divider turning squared voltage and resistance into power
`timescale 1ns/1ns
`default_nettype none
module bcm_power_div
  import bcm_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request
  input  wire logic        start_i,
  input  wire logic [31:0] num_i,
  input  wire logic [31:0] den_i,
  // answer
  output logic             busy_o,
  output logic             done_o,
  output logic [31:0]      quot_o
);
  import bcm_pkg::*;
  logic [32:0] rem_q;
  logic [31:0] quot_q;
  logic [5:0]  cnt_q;
  logic        busy_q;
  logic        done_q;

  wire  [32:0] shifted = {rem_q[31:0], quot_q[31]};
  wire  [33:0] diff    = {1'b0, shifted} - {2'h0, den_i};
  wire         fits    = ~diff[33];

  // one quotient bit a cycle: slow but tiny, and power changes slowly
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rem_q  <= 33'h0_0000_0000;
      quot_q <= 32'h0000_0000;
      cnt_q  <= 6'h00;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start_i && !busy_q) begin
        rem_q  <= 33'h0_0000_0000;
        quot_q <= num_i;
        cnt_q  <= DIV_STEPS;
        busy_q <= 1'b1;
      end else if (busy_q) begin
        rem_q  <= fits ? diff[32:0] : shifted;
        quot_q <= {quot_q[30:0], fits};
        cnt_q  <= cnt_q - 6'h01;
        if (cnt_q == 6'h01) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end

  assign busy_o = busy_q;
  assign done_o = done_q;
  assign quot_o = quot_q;
endmodule : bcm_power_div
`default_nettype wire

// [bcm_link_model.sv]
// behavioural dc-link and ballast resistor beyond the ballast pin
`timescale 1ns/1ns
`default_nettype none
module bcm_link_model #(
  parameter logic [15:0] DROP_MV = 16'h0032
)(
  // clock
  input  wire logic        clk_i,
  // pin and its polarity
  input  wire logic        ballast_i,
  input  wire logic        inv_i,
  // regenerated link level set by the bench
  input  wire logic [15:0] src_mv_i,
  // link voltage seen by the monitor
  output logic [15:0]      dclink_mv_o
);
  logic conduct;

  // switch conducts only at the pin's active level
  assign conduct = ballast_i ^ inv_i;

  // the resistor loads the link by a fixed step, so hysteresis matters
  always_ff @(posedge clk_i) begin
    dclink_mv_o <= conduct ? src_mv_i - DROP_MV : src_mv_i;
  end
endmodule : bcm_link_model
`default_nettype wire

// [bcm_ballast_monitor_tb.sv]
// self-checking bench for the ballast chopper monitor
`timescale 1ns/1ns
`default_nettype none
module bcm_ballast_monitor_tb;
  import bcm_pkg::*;
  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [31:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] dclink_mv;
  logic        ballast_o;
  logic        stage_off_o;
  logic [15:0] src_mv;
  logic        inv_q;
  logic [3:0]  sel_q;
  logic [31:0] q;
  int          fail_count;
  int          n_compared;
  int          k;

  // short tick keeps the thermal run brief
  bcm_ballast_monitor #(.TICK_CYC(100)) u_bcm_ballast_monitor (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dclink_mv_i(dclink_mv),
    .ballast_o(ballast_o), .stage_off_o(stage_off_o));

  bcm_link_model u_bcm_link_model (
    .clk_i(clk_i), .ballast_i(ballast_o), .inv_i(inv_q), .src_mv_i(src_mv),
    .dclink_mv_o(dclink_mv));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; nothing moves until ack is sampled high
  task automatic wb_xfer(input logic we, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_q;
    // only the watchdog ends a wait that never sees ack
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb_xfer(1'b1, {24'h000000, a}, d);
    if (a == REG_CTRL) inv_q <= d[CTRL_INV];
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, {24'h000000, a}, 32'h0000_0000);
    chk(q, exp);
  endtask : rd_chk

  // new link level, then let pin path and model settle
  task automatic set_src(input logic [15:0] v);
    @(posedge clk_i);
    src_mv <= v;
    repeat (6) @(posedge clk_i);
  endtask : set_src

  task automatic pin(input logic exp);
    chk({31'h0, ballast_o}, {31'h0, exp});
  endtask : pin

  initial begin
    #400000;
    fail_count++;
    conclude();
  end

  initial begin
    rst_i = 1'b1; wb_cyc_i = 1'b0; wb_stb_i = 1'b0; wb_we_i = 1'b0;
    wb_adr_i = 32'h0; wb_sel_i = 4'h0; wb_dat_i = 32'h0;
    src_mv = 16'h0000; inv_q = 1'b0; fail_count = 0; n_compared = 0;
    sel_q = 4'hF;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    // all parameters zero, so the fault must already be flagged
    rd_chk(REG_CTRL, 32'h0000_0000);
    rd_chk(REG_THRESH, 32'h0000_0000);
    rd_chk(REG_RES, 32'h0000_0000);
    rd_chk(REG_STATUS, 32'h0000_0004);
    rd_chk(REG_ERR_CODE, {16'h0000, CODE_PARAM});
    rd_chk(REG_ENERGY, 32'h0000_0000);
    wb_xfer(1'b0, 32'h0000_0100, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    $display("test reset done");

    wr(REG_RES, 32'h0000_03E8);
    wr(REG_COOL, 32'h0001_86A0);
    wr(REG_ST_LIMIT, 32'h0001_86A0);
    wr(REG_LT_LIMIT, 32'h0001_86A0);
    wr(REG_LT_WINDOW, 32'h0000_0002);
    wr(REG_THRESH, 32'h0000_5DC0);
    wr(REG_HYST, 32'h0000_07FF);
    // byte lane 0 only: upper bytes must keep their value
    sel_q = 4'h1;
    wr(REG_HYST, 32'hFFFF_FFD0);
    sel_q = 4'hF;
    wr(REG_OV_LIMIT, 32'h0000_7530);
    rd_chk(REG_THRESH, 32'h0000_5DC0);
    rd_chk(REG_HYST, 32'h0000_07D0);
    rd_chk(REG_STATUS, 32'h0000_0000);
    $display("test config done");

    set_src(16'h61A8);
    pin(1'b0);
    wr(REG_CTRL, 32'h0000_0001);
    set_src(16'h61A8);
    pin(1'b1);
    rd_chk(REG_STATUS, 32'h0000_0001);
    set_src(16'h59D8);
    pin(1'b1);
    set_src(16'h558C);
    pin(1'b0);
    set_src(16'h5DC0);
    pin(1'b0);
    set_src(16'h5DC1);
    pin(1'b1);
    set_src(16'h2710);
    pin(1'b0);
    $display("test hysteresis done");

    wr(REG_CTRL, 32'h0000_0003);
    set_src(16'h2710);
    pin(1'b1);
    set_src(16'h61A8);
    pin(1'b0);
    wr(REG_CTRL, 32'h0000_0001);
    set_src(16'h2710);
    $display("test polarity done");

    set_src(16'h7918);
    chk({31'h0, stage_off_o}, 32'h0000_0001);
    set_src(16'h2710);
    chk({31'h0, stage_off_o}, 32'h0000_0001);
    rd_chk(REG_STATUS, 32'h0000_0008);
    wr(REG_STATUS, 32'h0000_0008);
    rd_chk(REG_STATUS, 32'h0000_0000);
    chk({31'h0, stage_off_o}, 32'h0000_0000);
    $display("test overvoltage done");

    set_src(16'h61A8);
    pin(1'b1);
    wr(REG_RES, 32'h0000_0000);
    set_src(16'h61A8);
    pin(1'b0);
    rd_chk(REG_STATUS, 32'h0000_0004);
    rd_chk(REG_ERR_CODE, {16'h0000, CODE_PARAM});
    rd_chk(REG_ENERGY, 32'h0000_0000);
    wr(REG_RES, 32'h0000_03E8);
    $display("test parameter fault done");

    // tight limits: a few ticks of full power must overload
    wr(REG_ST_LIMIT, 32'h0000_03E8);
    wr(REG_LT_LIMIT, 32'h0000_03E8);
    set_src(16'h61A8);
    k = 0;
    do begin
      rd_chk(REG_CTRL, 32'h0000_0001);
      wb_xfer(1'b0, {24'h0, REG_STATUS}, 32'h0);
      k++;
    end while (q[ST_INHIBIT] !== 1'b1 && k < 200);
    chk({31'h0, q[ST_INHIBIT]}, 32'h0000_0001);
    chk({31'h0, q[ST_OVL_WARN]}, 32'h0000_0001);
    pin(1'b0);
    rd_chk(REG_ERR_CODE, {16'h0000, CODE_OVERLOAD});
    wb_xfer(1'b0, {24'h0, REG_ENERGY}, 32'h0);
    chk({31'h0, q != 32'h0}, 32'h0000_0001);
    set_src(16'h2710);
    k = 0;
    do begin
      wb_xfer(1'b0, {24'h0, REG_STATUS}, 32'h0);
      k++;
    end while (q[ST_INHIBIT] !== 1'b0 && k < 400);
    chk({31'h0, q[ST_INHIBIT]}, 32'h0000_0000);
    wr(REG_STATUS, 32'h0000_0010);
    rd_chk(REG_STATUS, 32'h0000_0000);
    set_src(16'h61A8);
    pin(1'b1);
    $display("test thermal done");
    conclude();
  end
endmodule : bcm_ballast_monitor_tb
`default_nettype wire
